//--- verilog/serial_master_unit_events.sv
// Task, event and shortcut registers of the serial master unit, AXI4-Lite slave
//
// Behaviour
// - Stopped flag sets when a transaction halts; reads 0 before; software writable.
// - Receive-end flag sets when receive buffer end is reached; reads 0 before; software writable.
// - Combined end flag sets only after both receive and transmit ends, or by a software write.
// - Transmit-end flag sets when transmit buffer end is reached; reads 0 before; software writable.
// - Shortcut enable, reset 0; when 1 each combined end fires start task.
// - Buffer end events rise as the memory engine finishes each buffer.
`timescale 1ns/1ps
`include "evreg_map.svh"

module serial_master_unit_events (
    input  logic               SYS_CLK,       // System clock, 125 MHz
    input  logic               RESET,         // Async reset, active high
    input  logic               AWVALID,       // Write address valid
    output logic               AWREADY,       // Write address ready
    input  logic [`ADDR_W-1:0] AWADDR,        // Write byte address
    input  logic               WVALID,        // Write data valid
    output logic               WREADY,        // Write data ready
    input  logic [31:0]        WDATA,         // Write data
    input  logic [3:0]         WSTRB,         // Write byte lanes
    output logic               BVALID,        // Write response valid
    input  logic               BREADY,        // Write response ready
    output logic [1:0]         BRESP,         // Write response code
    input  logic               ARVALID,       // Read address valid
    output logic               ARREADY,       // Read address ready
    input  logic [`ADDR_W-1:0] ARADDR,        // Read byte address
    output logic               RVALID,        // Read data valid
    input  logic               RREADY,        // Read data ready
    output logic [31:0]        RDATA,         // Read data
    output logic [1:0]         RRESP,         // Read response code
    input  logic               STOPPED_PULSE, // Engine: transaction halted
    input  logic               RX_END_PULSE,  // Engine: receive buffer done
    input  logic               TX_END_PULSE,  // Engine: transmit buffer done
    input  logic               STARTED_PULSE, // Engine: transaction started
    output logic               START_TASK,    // Start strobe from shortcut
    output logic               RESUME_TASK,   // Resume strobe to engine
    output logic               IRQ            // Level interrupt
);

    // Address decode shared by read and write paths
    function automatic evreg_pkg::reg_sel_t decode(input logic [`ADDR_W-1:0] addr);
        evreg_pkg::reg_sel_t sel;
        unique case (addr)
            `OFF_RESUME:     sel = evreg_pkg::SEL_RESUME;
            `OFF_STOPPED:    sel = evreg_pkg::SEL_STOPPED;
            `OFF_RXEND:      sel = evreg_pkg::SEL_RXEND;
            `OFF_BOTHEND:    sel = evreg_pkg::SEL_BOTHEND;
            `OFF_TXEND:      sel = evreg_pkg::SEL_TXEND;
            `OFF_STARTED:    sel = evreg_pkg::SEL_STARTED;
            `OFF_SHORTCUT:   sel = evreg_pkg::SEL_SHORTCUT;
            `OFF_IRQ_STATUS: sel = evreg_pkg::SEL_IRQ_STATUS;
            `OFF_IRQ_MASK:   sel = evreg_pkg::SEL_IRQ_MASK;
            default:         sel = evreg_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction

    // Write channel capture
    logic               aw_held;
    logic               w_held;
    logic [`ADDR_W-1:0] awaddr_q;
    logic [31:0]        wdata_q;
    logic [3:0]         wstrb_q;

    // Register state
    logic                 shortcut;
    logic [`EV_COUNT-1:0] mask;
    logic [`EV_COUNT-1:0] ev_q;
    logic [`EV_COUNT-1:0] status;
    logic [`EV_COUNT-1:0] ev_in;
    logic [`EV_COUNT-1:0] wr_ev;
    logic [`EV_COUNT-1:0] clr_status;
    logic                 both_end;

    // Channel handshakes
    wire aw_take = AWVALID & AWREADY;
    wire w_take  = WVALID & WREADY;
    wire ar_take = ARVALID & ARREADY;
    wire do_write = aw_held & w_held & ~BVALID;

    // Next state of the write path; address and data in either order
    wire next_aw_held = (aw_held | aw_take) & ~do_write;
    wire next_w_held  = (w_held | w_take) & ~do_write;
    wire next_bvalid  = do_write | (BVALID & ~BREADY);
    wire next_awready = ~next_aw_held & ~next_bvalid;
    wire next_wready  = ~next_w_held & ~next_bvalid;

    // Next state of the read path; one read under way at a time
    wire next_rvalid  = ar_take | (RVALID & ~RREADY);
    wire next_arready = ~next_rvalid;

    // Write decode
    evreg_pkg::reg_sel_t wr_sel;
    assign wr_sel = decode(awaddr_q);
    wire wr_lane0  = do_write & wstrb_q[0];
    wire wr_bit    = wdata_q[0];
    wire wr_mapped = (wr_sel != evreg_pkg::SEL_NONE);

    // Task strobe: only a written 1 resumes
    wire wr_resume = wr_lane0 & (wr_sel == evreg_pkg::SEL_RESUME) & wr_bit;

    // Event register write strobes
    assign wr_ev[`EV_STOPPED] = wr_lane0 & (wr_sel == evreg_pkg::SEL_STOPPED);
    assign wr_ev[`EV_RXEND]   = wr_lane0 & (wr_sel == evreg_pkg::SEL_RXEND);
    assign wr_ev[`EV_BOTHEND] = wr_lane0 & (wr_sel == evreg_pkg::SEL_BOTHEND);
    assign wr_ev[`EV_TXEND]   = wr_lane0 & (wr_sel == evreg_pkg::SEL_TXEND);
    assign wr_ev[`EV_STARTED] = wr_lane0 & (wr_sel == evreg_pkg::SEL_STARTED);

    // Interrupt status clears where a one is written
    wire wr_status = wr_lane0 & (wr_sel == evreg_pkg::SEL_IRQ_STATUS);
    assign clr_status = wr_status ? wdata_q[`EV_COUNT-1:0] : '0;
    wire wr_mask     = wr_lane0 & (wr_sel == evreg_pkg::SEL_IRQ_MASK);
    wire wr_shortcut = wr_lane0 & (wr_sel == evreg_pkg::SEL_SHORTCUT);

    // Events from the engine, combined end from both buffer ends
    assign ev_in[`EV_STOPPED] = STOPPED_PULSE;
    assign ev_in[`EV_RXEND]   = RX_END_PULSE;
    assign ev_in[`EV_BOTHEND] = both_end;
    assign ev_in[`EV_TXEND]   = TX_END_PULSE;
    assign ev_in[`EV_STARTED] = STARTED_PULSE;

    // Combined end fires only once both buffers are finished
    both_end_detect u_both_end (
        .clk      (SYS_CLK),
        .rst      (RESET),
        .start    (STARTED_PULSE),
        .rx_end   (RX_END_PULSE),
        .tx_end   (TX_END_PULSE),
        .both_end (both_end)
    );

    // Event flags and sticky interrupt status, one pair per event
    genvar gi;
    generate
        for (gi = 0; gi < `EV_COUNT; gi = gi + 1) begin : g_event
            // Readable event flag, software may write it
            sticky_flag u_event (
                .clk    (SYS_CLK),
                .rst    (RESET),
                .set    (ev_in[gi]),
                .wr_en  (wr_ev[gi]),
                .wr_val (wr_bit),
                .q      (ev_q[gi])
            );
            // Interrupt status bit, write one to clear
            sticky_flag u_status (
                .clk    (SYS_CLK),
                .rst    (RESET),
                .set    (ev_in[gi]),
                .wr_en  (clr_status[gi]),
                .wr_val (1'b0),
                .q      (status[gi])
            );
        end
    endgenerate

    // Read decode and data selection
    evreg_pkg::reg_sel_t rd_sel;
    assign rd_sel = decode(ARADDR);
    wire rd_mapped = (rd_sel != evreg_pkg::SEL_NONE);
    wire [31:0] rd_word =
        (rd_sel == evreg_pkg::SEL_STOPPED)    ? {31'h0, ev_q[`EV_STOPPED]} :
        (rd_sel == evreg_pkg::SEL_RXEND)      ? {31'h0, ev_q[`EV_RXEND]}   :
        (rd_sel == evreg_pkg::SEL_BOTHEND)    ? {31'h0, ev_q[`EV_BOTHEND]} :
        (rd_sel == evreg_pkg::SEL_TXEND)      ? {31'h0, ev_q[`EV_TXEND]}   :
        (rd_sel == evreg_pkg::SEL_STARTED)    ? {31'h0, ev_q[`EV_STARTED]} :
        (rd_sel == evreg_pkg::SEL_SHORTCUT)   ? {31'h0, shortcut}          :
        (rd_sel == evreg_pkg::SEL_IRQ_STATUS) ? {27'h0, status}            :
        (rd_sel == evreg_pkg::SEL_IRQ_MASK)   ? {27'h0, mask}              :
        `RESET_WORD;

    // Unmasked pending events
    wire irq_pending = |(status & mask);

    // Write address and data capture
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            awaddr_q <= '0;
            wdata_q  <= `RESET_WORD;
            wstrb_q  <= 4'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            if (aw_take) begin
                awaddr_q <= AWADDR;
            end
            if (w_take) begin
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
        end
    end

    // Write channel ready and response
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
            BVALID  <= 1'b0;
            BRESP   <= `RESP_OKAY;
        end else begin
            AWREADY <= next_awready;
            WREADY  <= next_wready;
            BVALID  <= next_bvalid;
            if (do_write) begin
                BRESP <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // Read channel
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= `RESET_WORD;
            RRESP   <= `RESP_OKAY;
        end else begin
            ARREADY <= next_arready;
            RVALID  <= next_rvalid;
            if (ar_take) begin
                RDATA <= rd_word;
                RRESP <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // Control registers
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            shortcut <= 1'b0;
            mask     <= '0;
        end else begin
            if (wr_shortcut) begin
                shortcut <= wr_bit;
            end
            if (wr_mask) begin
                mask <= wdata_q[`EV_COUNT-1:0];
            end
        end
    end

    // Task strobes and interrupt output
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            START_TASK  <= 1'b0;
            RESUME_TASK <= 1'b0;
            IRQ         <= 1'b0;
        end else begin
            START_TASK  <= both_end & shortcut;
            RESUME_TASK <= wr_resume;
            IRQ         <= irq_pending;
        end
    end

    // Checks on the block's own outputs and state
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);

    a_stopped_sets: assert property (
        STOPPED_PULSE |=> ev_q[`EV_STOPPED] && status[`EV_STOPPED]
    ) else $error("stopped event not flagged");

    a_rxend_sets: assert property (
        RX_END_PULSE |=> ev_q[`EV_RXEND]
    ) else $error("receive end event not flagged");

    a_rxend_cause: assert property (
        $rose(ev_q[`EV_RXEND]) |-> $past(RX_END_PULSE) || $past(wr_ev[`EV_RXEND])
    ) else $error("receive end flag rose without cause");

    a_end_cause: assert property (
        $rose(ev_q[`EV_BOTHEND]) |-> $past(both_end) || $past(wr_ev[`EV_BOTHEND])
    ) else $error("combined end flag rose without cause");

    a_end_both: assert property (
        (RX_END_PULSE && TX_END_PULSE) |=> both_end ##1 ev_q[`EV_BOTHEND]
    ) else $error("combined end missed after both ends");

    a_txend_sets: assert property (
        TX_END_PULSE |=> ev_q[`EV_TXEND] && status[`EV_TXEND]
    ) else $error("transmit end event not flagged");

    a_short_start: assert property (
        both_end |=> (START_TASK == $past(shortcut))
    ) else $error("start strobe does not follow shortcut");

    a_start_cause: assert property (
        START_TASK |-> $past(both_end) && $past(shortcut)
    ) else $error("start strobe without combined end");

    a_engine_end: assert property (
        RX_END_PULSE ##1 !wr_status[*2] |-> status[`EV_RXEND]
    ) else $error("receive end status lost");

    a_resume_pulse: assert property (
        wr_resume |=> RESUME_TASK ##1 !RESUME_TASK
    ) else $error("resume strobe wrong");

    a_resume_zero: assert property (
        (do_write && wr_sel == evreg_pkg::SEL_RESUME && !wr_bit) |=> !RESUME_TASK
    ) else $error("writing zero resumed");

    a_irq_level: assert property (
        irq_pending |=> IRQ
    ) else $error("interrupt not raised");

    a_stopped_cause: assert property (
        $rose(ev_q[`EV_STOPPED]) |-> $past(STOPPED_PULSE) || $past(wr_ev[`EV_STOPPED])
    ) else $error("stopped flag rose without cause");

    a_txend_cause: assert property (
        $rose(ev_q[`EV_TXEND]) |-> $past(TX_END_PULSE) || $past(wr_ev[`EV_TXEND])
    ) else $error("transmit end flag rose without cause");

    a_started_sets: assert property (
        STARTED_PULSE |=> ev_q[`EV_STARTED] && status[`EV_STARTED]
    ) else $error("started event not flagged");

    // Bus answers stand until the master takes them
    a_bvalid_hold: assert property (
        BVALID && !BREADY |=> BVALID && $stable(BRESP)
    ) else $error("write response dropped early");

    a_rvalid_hold: assert property (
        RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP)
    ) else $error("read data dropped early");

    // Main scenarios
    c_chained: cover property (both_end && shortcut ##1 START_TASK);
    c_resume:  cover property (RESUME_TASK);
    c_irq:     cover property ($rose(IRQ) ##[1:20] !IRQ);
    c_slverr:  cover property (BVALID && BRESP == `RESP_SLVERR);

endmodule

//--- verilog/evreg_map.svh
// Register offsets, field positions, reset values and codes of the event block
`ifndef EVREG_MAP_SVH
`define EVREG_MAP_SVH

`define ADDR_W         12
`define OFF_RESUME     12'h020
`define OFF_STOPPED    12'h104
`define OFF_RXEND      12'h110
`define OFF_BOTHEND    12'h118
`define OFF_TXEND      12'h120
`define OFF_STARTED    12'h14C
`define OFF_SHORTCUT   12'h200
`define OFF_IRQ_STATUS 12'h310
`define OFF_IRQ_MASK   12'h314

`define EV_STOPPED     0
`define EV_RXEND       1
`define EV_BOTHEND     2
`define EV_TXEND       3
`define EV_STARTED     4
`define EV_COUNT       5

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define RESET_WORD     32'h00000000

`endif

//--- verilog/evreg_pkg.sv
// Types shared by the event register block
package evreg_pkg;

    typedef enum logic [3:0] {
        SEL_NONE       = 4'h0,
        SEL_RESUME     = 4'h1,
        SEL_STOPPED    = 4'h2,
        SEL_RXEND      = 4'h3,
        SEL_BOTHEND    = 4'h4,
        SEL_TXEND      = 4'h5,
        SEL_STARTED    = 4'h6,
        SEL_SHORTCUT   = 4'h7,
        SEL_IRQ_STATUS = 4'h8,
        SEL_IRQ_MASK   = 4'h9
    } reg_sel_t;

endpackage

//--- verilog/sticky_flag.sv
// One sticky flag: hardware set beats a software write in the same cycle
`timescale 1ns/1ps
module sticky_flag (
    input  logic clk,    // System clock
    input  logic rst,    // Async reset, active high
    input  logic set,    // Hardware event pulse
    input  logic wr_en,  // Software write strobe
    input  logic wr_val, // Value written by software
    output logic q       // Flag state
);

    // Set first, then software write, else hold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (wr_en) begin
            q <= wr_val;
        end
    end

endmodule

//--- verilog/both_end_detect.sv
// Tracks buffer ends of one transaction and flags when both are done
`timescale 1ns/1ps
module both_end_detect (
    input  logic clk,      // System clock
    input  logic rst,      // Async reset, active high
    input  logic start,    // Transaction started pulse
    input  logic rx_end,   // Receive buffer end pulse
    input  logic tx_end,   // Transmit buffer end pulse
    output logic both_end  // One-cycle pulse, both buffers done
);

    logic rx_seen;
    logic tx_seen;

    // Either end may come first; the pair fires once
    wire rx_done    = rx_seen | rx_end;
    wire tx_done    = tx_seen | tx_end;
    wire fire       = rx_done & tx_done;
    wire next_rx    = start ? 1'b0 : (rx_done & ~fire);
    wire next_tx    = start ? 1'b0 : (tx_done & ~fire);

    // Seen flags clear at a new start or once the pair fired
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_seen  <= 1'b0;
            tx_seen  <= 1'b0;
            both_end <= 1'b0;
        end else begin
            rx_seen  <= next_rx;
            tx_seen  <= next_tx;
            both_end <= fire;
        end
    end

endmodule

//--- tb/engine_model.sv
// Behavioural model of the transfer engine that feeds the event pulses
`timescale 1ns/1ps
module engine_model (
    input  wire logic clk,           // System clock
    input  wire logic start_task,    // Start strobe from the block
    input  wire logic resume_task,   // Resume strobe from the block
    output logic      stopped_pulse, // Transaction halted
    output logic      rx_end_pulse,  // Receive buffer done
    output logic      tx_end_pulse,  // Transmit buffer done
    output logic      started_pulse  // Transaction started
);
    int start_seen  = 0;
    int resume_seen = 0;

    // Count the one-cycle task strobes
    always @(posedge clk) begin
        start_seen  <= start_seen + int'(start_task === 1'b1);
        resume_seen <= resume_seen + int'(resume_task === 1'b1);
    end

    // Idle lines at time zero
    initial begin
        {started_pulse, tx_end_pulse, rx_end_pulse, stopped_pulse} = 4'h0;
    end

    // One-cycle pulses; buffer ends mark the memory engine finishing
    task automatic fire(input logic [3:0] ev);
        @(posedge clk);
        {started_pulse, tx_end_pulse, rx_end_pulse, stopped_pulse} <= ev;
        @(posedge clk);
        {started_pulse, tx_end_pulse, rx_end_pulse, stopped_pulse} <= 4'h0;
    endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the event register block over AXI4-Lite
`timescale 1ns/1ps
`include "evreg_map.svh"
module tb;
    logic        sys_clk = 0;
    logic        reset   = 1;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr, araddr, a;
    logic [31:0] wdata, rd;
    logic [3:0]  wstrb, strb;
    logic        awready, wready, bvalid, arready, rvalid, start_task, resume_task, irq;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata;
    logic        stopped_p, rx_p, tx_p, started_p;
    int          fails = 0, n_compared = 0, k;
    logic [11:0] offs [9] = '{`OFF_RESUME, `OFF_STOPPED, `OFF_RXEND, `OFF_BOTHEND,
        `OFF_TXEND, `OFF_STARTED, `OFF_SHORTCUT, `OFF_IRQ_STATUS, `OFF_IRQ_MASK};

    // Free-running system clock, 8 ns
    always #4 sys_clk = ~sys_clk;

    serial_master_unit_events dut (
        .SYS_CLK(sys_clk), .RESET(reset),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
        .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
        .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
        .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
        .STOPPED_PULSE(stopped_p), .RX_END_PULSE(rx_p), .TX_END_PULSE(tx_p),
        .STARTED_PULSE(started_p), .START_TASK(start_task),
        .RESUME_TASK(resume_task), .IRQ(irq)
    );

    engine_model eng (
        .clk(sys_clk), .start_task(start_task), .resume_task(resume_task),
        .stopped_pulse(stopped_p), .rx_end_pulse(rx_p), .tx_end_pulse(tx_p),
        .started_pulse(started_p)
    );

    // Closing report
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
            fails++;
        end
    endtask

    // Bus write, response code left in rs
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        awaddr  <= ad;
        wdata   <= d;
        wstrb   <= strb;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (i == 40) begin
            fails++;
            give_verdict();
        end
    endtask

    // Bus read, data in rd and response code in rs
    task automatic rdr(input logic [11:0] ad);
        int i;
        @(posedge sys_clk);
        araddr  <= ad;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (i == 40) begin
            fails++;
            give_verdict();
        end
    endtask

    // Read and compare
    task automatic rchk(input string nm, input logic [11:0] ad, input logic [31:0] exp);
        rdr(ad);
        chk(nm, exp, rd);
    endtask

    // Main sequence
    initial begin
        {awaddr, araddr, wdata, wstrb} <= '0;
        strb = 4'hF;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        // Every register reads zero after reset
        foreach (offs[k]) rchk("reset value", offs[k], 32'h0);
        // Unmapped place answers with an error both ways
        rdr(12'h004);
        chk("unmapped rresp", {30'h0, `RESP_SLVERR}, {30'h0, rs});
        chk("unmapped rdata", 32'h0, rd);
        wr(12'h004, 32'h1);
        chk("unmapped bresp", {30'h0, `RESP_SLVERR}, {30'h0, rs});
        // Stopped and started flags: set by hardware, written by software
        for (k = 0; k < 2; k++) begin
            eng.fire(k ? 4'h8 : 4'h1);
            a = k ? `OFF_STARTED : `OFF_STOPPED;
            rchk("flag set", a, 32'h1);
            wr(a, 32'h0);
            rchk("flag cleared", a, 32'h0);
            wr(a, 32'h1);
            rchk("flag written", a, 32'h1);
            wr(a, 32'h0);
        end
        // Combined end waits for both buffer ends
        eng.fire(4'h2);
        rchk("rx end", `OFF_RXEND, 32'h1);
        rchk("tx end early", `OFF_TXEND, 32'h0);
        rchk("both end early", `OFF_BOTHEND, 32'h0);
        eng.fire(4'h4);
        rchk("tx end", `OFF_TXEND, 32'h1);
        rchk("both end", `OFF_BOTHEND, 32'h1);
        chk("no chained start", 32'h0, 32'(eng.start_seen));
        // Shortcut on: both ends in one cycle chain a start
        wr(`OFF_BOTHEND, 32'h0);
        strb = 4'hE;
        wr(`OFF_SHORTCUT, 32'h1);
        chk("lane off bresp", {30'h0, `RESP_OKAY}, {30'h0, rs});
        rchk("shortcut lane off", `OFF_SHORTCUT, 32'h0);
        strb = 4'hF;
        wr(`OFF_SHORTCUT, 32'h1);
        chk("bresp", {30'h0, `RESP_OKAY}, {30'h0, rs});
        rchk("shortcut", `OFF_SHORTCUT, 32'h1);
        chk("rresp", {30'h0, `RESP_OKAY}, {30'h0, rs});
        eng.fire(4'h6);
        rchk("both end same cycle", `OFF_BOTHEND, 32'h1);
        chk("chained start", 32'h1, 32'(eng.start_seen));
        // A new start forgets a half-finished pair
        wr(`OFF_BOTHEND, 32'h0);
        eng.fire(4'h8);
        eng.fire(4'h2);
        eng.fire(4'h8);
        eng.fire(4'h4);
        rchk("both end after restart", `OFF_BOTHEND, 32'h0);
        chk("no start after restart", 32'h1, 32'(eng.start_seen));
        wr(`OFF_SHORTCUT, 32'h0);
        // Resume strobe only for a written one
        wr(`OFF_RESUME, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk("resume on zero", 32'h0, 32'(eng.resume_seen));
        wr(`OFF_RESUME, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("resume strobe", 32'h1, 32'(eng.resume_seen));
        rchk("resume reads zero", `OFF_RESUME, 32'h0);
        // Interrupt: masked source, raise, mask off, clear
        eng.fire(4'h8); // Drops the half-finished pair left above
        wr(`OFF_IRQ_STATUS, 32'h1F);
        wr(`OFF_IRQ_MASK, 32'h2);
        eng.fire(4'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        eng.fire(4'h2);
        repeat (2) @(posedge sys_clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        rchk("irq status", `OFF_IRQ_STATUS, 32'h3);
        wr(`OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk("irq mask off", 32'h0, {31'h0, irq});
        wr(`OFF_IRQ_MASK, 32'h2);
        wr(`OFF_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rchk("irq status cleared", `OFF_IRQ_STATUS, 32'h1);
        give_verdict();
    end
endmodule
